// ---- serdes_regs_pkg.sv ----
// Constants and carrier types for the serializer/deserializer register bank
package serdes_regs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RX_IRQ_STATUS_OFS   = 8'h08;
  localparam logic [7:0] RX_VALID_MASK_A_OFS = 8'h0A;
  localparam logic [7:0] RX_DATA_BYTE_B_OFS  = 8'h0B;
  localparam logic [7:0] RX_VALID_MASK_B_OFS = 8'h0C;
  localparam logic [7:0] TX_IRQ_ENABLE_OFS   = 8'h0D;
  localparam logic [7:0] TX_IRQ_STATUS_OFS   = 8'h0E;
  localparam logic [7:0] TX_DATA_OFS         = 8'h0F;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         RX_ALL_VALID_A_BIT = 3;
  localparam int         RX_ALL_VALID_B_BIT = 7;
  localparam int         TX_EMPTY_BIT       = 0;
  localparam int         TX_DONE_BIT        = 1;
  localparam int         TX_OVERFLOW_BIT    = 2;
  localparam int         TX_UNDERFLOW_BIT   = 3;
  localparam logic [3:0] TX_FLAGS_MASK      = 4'hF;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [3:0] TX_FLAGS_RESET     = 4'h0;
  localparam logic [2:0] BIT_CNT_RESET      = 3'h0;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       load;
    logic [7:0] valid;
  } rx_a_in_s;

  typedef struct packed {
    logic bit_stb;
    logic bit_data;
    logic bit_valid;
    logic eof;
  } rx_b_in_s;

  typedef struct packed {
    logic underflow;
    logic overflow;
    logic done;
    logic empty;
  } tx_events_s;

endpackage : serdes_regs_pkg

// ---- serdes_rx_valid_tx_irq_enable.sv ----
// Receive valid masks, channel B data byte and transmit interrupt enable bank
`timescale 1ns/100ps
`default_nettype none

module serdes_rx_valid_tx_irq_enable (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire serdes_regs_pkg::reg_req_s  i_reg_req,
  input  wire serdes_regs_pkg::rx_a_in_s  i_rx_a,
  input  wire serdes_regs_pkg::rx_b_in_s  i_rx_b,
  input  wire serdes_regs_pkg::tx_events_s i_tx_ev,
  input  wire logic                       i_rx_mode,
  input  wire logic                       i_tx_mode,
  output logic [7:0]                      o_reg_rdata,
  output logic                            o_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] rx_valid_mask_a;
    logic [7:0] rx_data_byte_b;
    logic [7:0] rx_valid_mask_b;
    logic [7:0] asm_data_b;
    logic [7:0] asm_valid_b;
    logic [2:0] bit_cnt_b;
    logic       all_valid_a;
    logic       all_valid_b;
    logic [7:0] tx_irq_enable;
    logic [3:0] tx_flags;
    logic [7:0] rdata;
    logic       irq;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // All eight bits marked valid
  function automatic logic all_ones(input logic [7:0] mask);
    all_ones = &mask;
  endfunction : all_ones

  logic       rd_tx_status;
  logic       wr_tx_data;
  logic       b_load;
  logic [7:0] b_data_now;
  logic [7:0] b_valid_now;
  logic [3:0] tx_set;

  assign rd_tx_status = i_reg_req.rd && (i_reg_req.addr == serdes_regs_pkg::TX_IRQ_STATUS_OFS);
  assign wr_tx_data   = i_reg_req.wr && (i_reg_req.addr == serdes_regs_pkg::TX_DATA_OFS);
  assign tx_set       = {i_tx_ev.underflow, i_tx_ev.overflow, i_tx_ev.done, i_tx_ev.empty};

  // Next-state logic
  always_comb begin
    state_next  = state_reg;
    b_data_now  = state_reg.asm_data_b;
    b_valid_now = state_reg.asm_valid_b;
    b_load      = i_rx_b.eof;

    // Channel A byte load captures the mask
    if (i_rx_a.load) begin
      state_next.rx_valid_mask_a = i_rx_a.valid;
      state_next.all_valid_a     = all_ones(i_rx_a.valid);
    end

    // Channel B bits land at rising positions
    if (i_rx_b.bit_stb) begin
      b_data_now[state_reg.bit_cnt_b]  = i_rx_b.bit_data;
      b_valid_now[state_reg.bit_cnt_b] = i_rx_b.bit_valid;
      state_next.bit_cnt_b = state_reg.bit_cnt_b + 3'h1;
      if (state_reg.bit_cnt_b == 3'h7) begin
        b_load = 1'b1;
      end
    end
    state_next.asm_data_b  = b_data_now;
    state_next.asm_valid_b = b_valid_now;
    if (b_load) begin
      state_next.rx_data_byte_b  = b_data_now;
      state_next.rx_valid_mask_b = b_valid_now;
      state_next.all_valid_b     = all_ones(b_valid_now);
      state_next.asm_data_b      = serdes_regs_pkg::REG_RESET;
      state_next.asm_valid_b     = serdes_regs_pkg::REG_RESET;
      state_next.bit_cnt_b       = serdes_regs_pkg::BIT_CNT_RESET;
    end

    // Only the enable register stores written data; masks ignore writes
    if (i_reg_req.wr && (i_reg_req.addr == serdes_regs_pkg::TX_IRQ_ENABLE_OFS)) begin
      state_next.tx_irq_enable = i_reg_req.wdata;
    end

    // Tx flags: clear by read or data write, set wins
    if (rd_tx_status) begin
      state_next.tx_flags = state_next.tx_flags & 4'h1;
    end
    if (wr_tx_data) begin
      state_next.tx_flags[serdes_regs_pkg::TX_EMPTY_BIT] = 1'b0;
    end
    state_next.tx_flags = state_next.tx_flags | tx_set;

    // Read data mux, tx and rx status gated by mode
    unique case (i_reg_req.addr)
      serdes_regs_pkg::RX_IRQ_STATUS_OFS: begin
        state_next.rdata = serdes_regs_pkg::REG_RESET;
        state_next.rdata[serdes_regs_pkg::RX_ALL_VALID_A_BIT] = state_reg.all_valid_a & i_rx_mode;
        state_next.rdata[serdes_regs_pkg::RX_ALL_VALID_B_BIT] = state_reg.all_valid_b & i_rx_mode;
      end
      serdes_regs_pkg::RX_VALID_MASK_A_OFS: state_next.rdata = state_reg.rx_valid_mask_a;
      serdes_regs_pkg::RX_DATA_BYTE_B_OFS:  state_next.rdata = state_reg.rx_data_byte_b;
      serdes_regs_pkg::RX_VALID_MASK_B_OFS: state_next.rdata = state_reg.rx_valid_mask_b;
      serdes_regs_pkg::TX_IRQ_ENABLE_OFS:   state_next.rdata = state_reg.tx_irq_enable;
      serdes_regs_pkg::TX_IRQ_STATUS_OFS:
        state_next.rdata = {4'h0, state_reg.tx_flags & {4{i_tx_mode}}};
      default:                              state_next.rdata = serdes_regs_pkg::REG_RESET;
    endcase
    if (!i_reg_req.rd) begin
      state_next.rdata = state_reg.rdata;
    end

    // Enabled tx flags drive the request; all-valid flags never do
    state_next.irq = i_tx_mode
      && |(state_next.tx_flags & state_next.tx_irq_enable[3:0]);
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata = state_reg.rdata;
  assign o_irq       = state_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_status_read;
    i_reg_req.rd && (i_reg_req.addr == serdes_regs_pkg::TX_IRQ_STATUS_OFS) && i_tx_mode;
  endsequence

  sequence s_no_new_events;
    !i_tx_ev.underflow && !i_tx_ev.overflow && !i_tx_ev.done;
  endsequence

  mask_a_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_rx_a.load |=> state_reg.rx_valid_mask_a == $past(i_rx_a.valid))
    else $error("channel A mask not captured");

  all_valid_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_reg.all_valid_a |-> state_reg.rx_valid_mask_a == 8'hFF)
    else $error("channel A all-valid with partial mask");

  all_valid_b_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state_reg.all_valid_b |-> state_reg.rx_valid_mask_b == 8'hFF)
    else $error("channel B all-valid with partial mask");

  mask_write_ignored_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_reg_req.wr && !i_rx_a.load) |=> $stable(state_reg.rx_valid_mask_a))
    else $error("channel A mask changed by write");

  first_bit_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rx_b.bit_stb && state_reg.bit_cnt_b == 3'h0 && !i_rx_b.eof)
      |=> state_reg.asm_data_b[0] == $past(i_rx_b.bit_data))
    else $error("first channel B bit not at bit 0");

  status_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (s_status_read ##0 s_no_new_events) |=> state_reg.tx_flags[3:1] == 3'h0)
    else $error("tx flags not cleared by read");

  read_value_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_reg_req.rd && i_reg_req.addr == serdes_regs_pkg::TX_IRQ_STATUS_OFS && !i_tx_mode)
      |=> o_reg_rdata == 8'h00)
    else $error("tx status nonzero outside transmit mode");

  underflow_irq_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_tx_ev.underflow && i_tx_mode && state_next.tx_irq_enable[3]) |=> o_irq)
    else $error("enabled underflow did not interrupt");

  irq_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_irq |-> |(state_reg.tx_flags & state_reg.tx_irq_enable[3:0]))
    else $error("interrupt without enabled flag");

  set_wins_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (s_status_read ##0 i_tx_ev.overflow) |=> state_reg.tx_flags[2])
    else $error("overflow lost during clearing read");

endmodule : serdes_rx_valid_tx_irq_enable

`default_nettype wire

// ---- serdes_host_model.sv ----
// Host-side register port driver for the serializer register bank
`timescale 1ns/100ps
`default_nettype none

module serdes_host_model (
  input  wire logic                      i_ref_clk,
  input  wire logic [7:0]                i_rdata,
  output var  serdes_regs_pkg::reg_req_s o_req
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial o_req = '0;

  // One write strobe; reserved enable bits always sent as zero
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] wd;
    wd = data;
    if (addr == serdes_regs_pkg::TX_IRQ_ENABLE_OFS) wd[7:4] = 4'h0;
    @(negedge i_ref_clk);
    o_req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: wd};
    @(negedge i_ref_clk);
    // Strobe drops and stale data flips in one assignment
    o_req = '{addr: o_req.addr, wr: 1'b0, rd: 1'b0, wdata: ~wd};
  endtask : wr

  // One read strobe; data taken once the answering edge has landed
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_ref_clk);
    o_req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge i_ref_clk);
    o_req.rd = 1'b0;
    data     = i_rdata;
  endtask : rd
endmodule : serdes_host_model
`default_nettype wire

// ---- serdes_rx_valid_tx_irq_enable_tb_top.sv ----
// Self-checking bench for the receive mask and transmit interrupt enable bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module serdes_rx_valid_tx_irq_enable_tb_top;
  logic                        ref_clk, rst, rx_mode, tx_mode, irq;
  logic [7:0]                  rdata, rv;
  serdes_regs_pkg::reg_req_s   req;
  serdes_regs_pkg::rx_a_in_s   rx_a;
  serdes_regs_pkg::rx_b_in_s   rx_b;
  serdes_regs_pkg::tx_events_s tx_ev;
  int                          bad_count = 0;
  int                          num_checks = 0;

  serdes_rx_valid_tx_irq_enable dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_reg_req(req),
    .i_rx_a(rx_a), .i_rx_b(rx_b), .i_tx_ev(tx_ev), .i_rx_mode(rx_mode),
    .i_tx_mode(tx_mode), .o_reg_rdata(rdata), .o_irq(irq));
  serdes_host_model host (.i_ref_clk(ref_clk), .i_rdata(rdata), .o_req(req));

  // ****************************************
  // Clock and helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
    host.rd(addr, rv);
    `CHK("register read", exp, rv)
  endtask : chk_rd

  // Channel B bits, LSB first, end of frame with the last one if asked
  task automatic send_b(input logic [7:0] d, input logic [7:0] v, input int n, input logic e);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      rx_b = '{bit_stb: 1'b1, bit_data: d[i], bit_valid: v[i], eof: e && (i == n - 1)};
    end
    @(negedge ref_clk);
    rx_b = '0;
  endtask : send_b

  task automatic load_a(input logic [7:0] v);
    @(negedge ref_clk);
    rx_a = '{load: 1'b1, valid: v};
    @(negedge ref_clk);
    rx_a.load = 1'b0;
  endtask : load_a

  task automatic pulse_ev(input int i);
    @(negedge ref_clk);
    tx_ev = serdes_regs_pkg::tx_events_s'(4'(1 << i));
    @(negedge ref_clk);
    tx_ev = '0;
  endtask : pulse_ev

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    rst = 1'b1; rx_a = '0; rx_b = '0; tx_ev = '0; rx_mode = 1'b1; tx_mode = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk_rd(8'h0A, 8'h00);
    chk_rd(8'h0B, 8'h00);
    chk_rd(8'h0C, 8'h00);
    chk_rd(8'h0D, 8'h00);
    chk_rd(8'h20, 8'h00);
    host.wr(8'h0D, 8'hFF);
    chk_rd(8'h0D, 8'h0F);
    host.wr(8'h0A, 8'hFF);
    host.wr(8'h0C, 8'hFF);
    chk_rd(8'h0A, 8'h00);
    chk_rd(8'h0C, 8'h00);
    $display("test registers done");
    load_a(8'hA5);
    chk_rd(8'h0A, 8'hA5);
    chk_rd(8'h08, 8'h00);
    load_a(8'hFF);
    chk_rd(8'h08, 8'h08);
    rx_mode = 1'b0;
    chk_rd(8'h08, 8'h00);
    rx_mode = 1'b1;
    send_b(8'h96, 8'hF7, 8, 1'b0);
    chk_rd(8'h0B, 8'h96);
    chk_rd(8'h0C, 8'hF7);
    chk_rd(8'h08, 8'h08);
    send_b(8'h3C, 8'hFF, 8, 1'b0);
    chk_rd(8'h0B, 8'h3C);
    chk_rd(8'h08, 8'h88);
    send_b(8'h05, 8'hFF, 3, 1'b1);
    chk_rd(8'h0C, 8'h07);
    chk_rd(8'h08, 8'h08);
    $display("test receive done");
    tx_mode = 1'b1;
    host.wr(8'h0D, 8'h00);
    for (int i = 0; i < 4; i++) pulse_ev(i);
    `CHK("irq all disabled", 1'b0, irq)
    chk_rd(8'h0E, 8'h0F);
    chk_rd(8'h0E, 8'h01);
    host.wr(8'h0F, 8'h00);
    chk_rd(8'h0E, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h0D, 8'(1 << i));
      pulse_ev((i + 1) % 4);
      `CHK("irq other source", 1'b0, irq)
      pulse_ev(i);
      `CHK("irq own source", 1'b1, irq)
      host.rd(8'h0E, rv);
      host.wr(8'h0F, 8'h00);
      `CHK("irq after clear", 1'b0, irq)
    end
    // Event lands in the same cycle as the clearing read
    fork
      pulse_ev(2);
      host.rd(8'h0E, rv);
    join
    chk_rd(8'h0E, 8'h04);
    tx_mode = 1'b0;
    pulse_ev(3);
    `CHK("irq idle", 1'b0, irq)
    chk_rd(8'h0E, 8'h00);
    // Idle read clears too; set again while idle
    pulse_ev(3);
    tx_mode = 1'b1;
    chk_rd(8'h0E, 8'h08);
    $display("test transmit done");
    wrap_up();
  end
endmodule : serdes_rx_valid_tx_irq_enable_tb_top
`default_nettype wire
